// ===== inc/dps_defines.vh
// constants shared by the dual port synchronous memory with parity checker
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH

// ************************************************************
// array geometry
// ************************************************************
`define DPS_WORDS        32768
`define DPS_AW           15
`define DPS_DW           9
`define DPS_BYTE_W       8
`define DPS_CHECK_POS    8

// ************************************************************
// pin synchroniser
// ************************************************************
`define DPS_SYNC_STAGES  3
`define DPS_PIN_W        41

// positions of the pins inside the synchroniser vector
`define DPS_PIN_K        0
`define DPS_PIN_IDX_LO   1
`define DPS_PIN_IDX_HI   15
`define DPS_PIN_CSL      16
`define DPS_PIN_CSH      17
`define DPS_PIN_STORE    18
`define DPS_PIN_PCAP     19
`define DPS_PIN_SCAP     20
`define DPS_PIN_PDRV     21
`define DPS_PIN_SDRV     22
`define DPS_PIN_PBUS_LO  23
`define DPS_PIN_PBUS_HI  31
`define DPS_PIN_SBUS_LO  32
`define DPS_PIN_SBUS_HI  40

// ************************************************************
// reset values
// ************************************************************
`define DPS_RST_FAULT_N  1'b1
`define DPS_RST_OE       1'b0
`define DPS_RST_WORD     9'h000
`define DPS_RST_IDX      15'h0000
`define DPS_RST_PINS     41'h000_0000_0000

// ************************************************************
// access pipeline states
// ************************************************************
`define DPS_ST_IDLE      2'h0
`define DPS_ST_ACCESS    2'h1
`define DPS_ST_VALID     2'h2

`endif

// ===== design/dps_mem.v
// single port array of 32K words by 9 bits with registered read data
`timescale 1ns/1ns
`include "dps_defines.vh"

module dps_mem (
  input  wire                 clk_in,
  input  wire                 arst_n_in,
  input  wire                 clk_en_in,
  input  wire                 en_in,
  input  wire                 we_in,
  input  wire [`DPS_AW-1:0]   addr_in,
  input  wire [`DPS_DW-1:0]   wdata_in,
  output reg  [`DPS_DW-1:0]   rdata_out
);

  // ************************************************************
  // storage
  // ************************************************************
  // the array itself has no reset: contents are undefined at power-up
  reg [`DPS_DW-1:0] mem_q [0:`DPS_WORDS-1];

  always @(posedge clk_in) begin
    if (clk_en_in && en_in && we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= `DPS_RST_WORD;
    end else if (clk_en_in && en_in && !we_in) begin
      rdata_out <= mem_q[addr_in];
    end
  end

endmodule

// ===== design/dps_top.v
// dual port synchronous 32K x 9 memory with streaming and odd parity checker
`timescale 1ns/1ns
`include "dps_defines.vh"

module dps_top (
  input  wire                    clk_in,
  input  wire                    arst_n_in,
  input  wire                    clk_en_in,
  input  wire                    dev_clk_in,
  input  wire [`DPS_AW-1:0]      word_index_in,
  input  wire                    chip_sel_low_in,
  input  wire                    chip_sel_high_in,
  input  wire                    store_sel_n_in,
  input  wire                    proc_port_capture_n_in,
  input  wire                    sys_port_capture_n_in,
  input  wire                    proc_port_drive_n_in,
  input  wire                    sys_port_drive_n_in,
  input  wire [`DPS_BYTE_W-1:0]  proc_port_bus_in,
  input  wire                    proc_port_check_bit_in,
  input  wire [`DPS_BYTE_W-1:0]  sys_port_bus_in,
  input  wire                    sys_port_check_bit_in,
  output reg  [`DPS_BYTE_W-1:0]  proc_port_bus_out,
  output reg                     proc_port_check_bit_out,
  output reg                     proc_port_oe_out,
  output reg  [`DPS_BYTE_W-1:0]  sys_port_bus_out,
  output reg                     sys_port_check_bit_out,
  output reg                     sys_port_oe_out,
  output reg                     parity_fault_n_out,
  output reg                     parity_fault_oe_out
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire [`DPS_PIN_W-1:0] pins_raw;
  reg  [`DPS_PIN_W-1:0] sync1_q;
  reg  [`DPS_PIN_W-1:0] sync2_q;
  reg  [`DPS_PIN_W-1:0] sync3_q;
  reg  [`DPS_PIN_W-1:0] pins_q;

  assign pins_raw = {sys_port_check_bit_in, sys_port_bus_in,
                     proc_port_check_bit_in, proc_port_bus_in,
                     sys_port_drive_n_in, proc_port_drive_n_in,
                     sys_port_capture_n_in, proc_port_capture_n_in,
                     store_sel_n_in, chip_sel_high_in, chip_sel_low_in,
                     word_index_in, dev_clk_in};

  // every pin is asynchronous to clk_in; a value is taken once the
  // second and third stage agree, so a glitch of one cycle is dropped
  genvar gi;
  generate
    for (gi = 0; gi < `DPS_PIN_W; gi = gi + 1) begin : g_sync
      always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          pins_q[gi]  <= 1'b0;
        end else if (clk_en_in) begin
          sync1_q[gi] <= pins_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            pins_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  wire                   k_lvl      = pins_q[`DPS_PIN_K];
  wire [`DPS_AW-1:0]     idx_pin    = pins_q[`DPS_PIN_IDX_HI:`DPS_PIN_IDX_LO];
  wire                   csl_pin    = pins_q[`DPS_PIN_CSL];
  wire                   csh_pin    = pins_q[`DPS_PIN_CSH];
  wire                   store_pin  = pins_q[`DPS_PIN_STORE];
  wire                   pcap_pin   = pins_q[`DPS_PIN_PCAP];
  wire                   scap_pin   = pins_q[`DPS_PIN_SCAP];
  wire                   pdrv_n     = pins_q[`DPS_PIN_PDRV];
  wire                   sdrv_n     = pins_q[`DPS_PIN_SDRV];
  wire [`DPS_DW-1:0]     pword_pin  = pins_q[`DPS_PIN_PBUS_HI:`DPS_PIN_PBUS_LO];
  wire [`DPS_DW-1:0]     sword_pin  = pins_q[`DPS_PIN_SBUS_HI:`DPS_PIN_SBUS_LO];

  // ************************************************************
  // device clock edges
  // ************************************************************
  reg  k_prev_q;
  wire k_rise = k_lvl & ~k_prev_q;
  wire k_fall = ~k_lvl & k_prev_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      k_prev_q <= 1'b0;
    end else if (clk_en_in) begin
      k_prev_q <= k_lvl;
    end
  end

  // ************************************************************
  // falling edge capture: word index and chip selects
  // ************************************************************
  reg [`DPS_AW-1:0] idx_q;
  reg               sel_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idx_q <= `DPS_RST_IDX;
      sel_q <= 1'b0;
    end else if (clk_en_in && k_fall) begin
      idx_q <= idx_pin;
      sel_q <= ~csl_pin & csh_pin;
    end
  end

  // ************************************************************
  // rising edge capture: controls and port data
  // ************************************************************
  reg               store_q;
  reg               pcap_q;
  reg               scap_q;
  reg               cyc_sel_q;
  reg [`DPS_DW-1:0] pword_q;
  reg [`DPS_DW-1:0] sword_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      store_q   <= 1'b1;
      pcap_q    <= 1'b1;
      scap_q    <= 1'b1;
      cyc_sel_q <= 1'b0;
      pword_q   <= `DPS_RST_WORD;
      sword_q   <= `DPS_RST_WORD;
    end else if (clk_en_in && k_rise) begin
      store_q   <= store_pin;
      pcap_q    <= pcap_pin;
      scap_q    <= scap_pin;
      cyc_sel_q <= sel_q;
      pword_q   <= pword_pin;
      sword_q   <= sword_pin;
    end
  end

  // ************************************************************
  // cycle decode
  // ************************************************************
  // combinations outside the documented set are not guarded against;
  // the decode below simply falls into one of the legal cases
  wire rd_cyc   = cyc_sel_q & store_q & pcap_q & scap_q;
  wire one_cap  = pcap_q ^ scap_q;
  wire wr_cyc   = cyc_sel_q & ~store_q & one_cap;
  wire strm_cyc = cyc_sel_q & one_cap;
  // a port sources the latch unless it is the one capturing
  wire p_active = cyc_sel_q & pcap_q & (~scap_q | store_q);
  wire s_active = cyc_sel_q & scap_q & (~pcap_q | store_q);
  wire [`DPS_DW-1:0] cap_word = pcap_q ? sword_q : pword_q;

  // ************************************************************
  // access pipeline
  // ************************************************************
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_ACCESS = 2'h1;
  localparam [1:0] ST_VALID  = 2'h2;
  reg [1:0] st_q;
  reg [1:0] st_d;

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (k_rise) begin
          st_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        st_d = ST_VALID;
      end
      ST_VALID: begin
        if (k_rise) begin
          st_d = ST_ACCESS;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= ST_IDLE;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  wire acc_go = (st_q == ST_ACCESS);
  reg  chk_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      chk_q <= 1'b0;
    end else if (clk_en_in) begin
      chk_q <= acc_go;
    end
  end

  // ************************************************************
  // array
  // ************************************************************
  wire [`DPS_DW-1:0] rd_word;

  // the write is a single internal pulse one cycle after the rising edge
  dps_mem u_mem (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .clk_en_in (clk_en_in),
    .en_in     (acc_go & (rd_cyc | wr_cyc)),
    .we_in     (wr_cyc),
    .addr_in   (idx_q),
    .wdata_in  (cap_word),
    .rdata_out (rd_word)
  );

  // internal bus word: array data on reads, captured data when streaming
  wire [`DPS_DW-1:0] bus_word = rd_cyc ? rd_word : cap_word;
  wire               bus_ok   = (st_q == ST_VALID) & (rd_cyc | strm_cyc);

  // ************************************************************
  // output latches
  // ************************************************************
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      proc_port_bus_out       <= 8'h00;
      proc_port_check_bit_out <= 1'b0;
      sys_port_bus_out        <= 8'h00;
      sys_port_check_bit_out  <= 1'b0;
    end else if (clk_en_in && k_lvl && bus_ok) begin
      // transparent only while the device clock is high, held while low
      if (p_active) begin
        proc_port_bus_out       <= bus_word[`DPS_BYTE_W-1:0];
        proc_port_check_bit_out <= bus_word[`DPS_CHECK_POS];
      end
      if (s_active) begin
        sys_port_bus_out        <= bus_word[`DPS_BYTE_W-1:0];
        sys_port_check_bit_out  <= bus_word[`DPS_CHECK_POS];
      end
    end
  end

  // ************************************************************
  // drivers
  // ************************************************************
  // drive enables bypass the device clock; they only pass the pin
  // synchroniser, which is the cost of running on one system clock
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      proc_port_oe_out <= `DPS_RST_OE;
      sys_port_oe_out  <= `DPS_RST_OE;
    end else if (clk_en_in) begin
      proc_port_oe_out <= p_active & bus_ok & ~pdrv_n;
      sys_port_oe_out  <= s_active & bus_ok & ~sdrv_n;
    end
  end

  // ************************************************************
  // parity checker
  // ************************************************************
  reg pend_ok_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend_ok_q           <= `DPS_RST_FAULT_N;
      parity_fault_n_out  <= `DPS_RST_FAULT_N;
      parity_fault_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      if (k_rise) begin
        parity_fault_n_out  <= pend_ok_q;
        parity_fault_oe_out <= ~pend_ok_q;
        pend_ok_q           <= `DPS_RST_FAULT_N;
      end else if (chk_q) begin
        // only a read with some port driving counts as a read cycle
        if (rd_cyc & ((p_active & ~pdrv_n) | (s_active & ~sdrv_n))) begin
          pend_ok_q <= (bus_word[`DPS_CHECK_POS] ==
                        ~(^bus_word[`DPS_BYTE_W-1:0]));
        end else begin
          pend_ok_q <= `DPS_RST_FAULT_N;
        end
      end
    end
  end

endmodule

// ===== testbench/dps_chk_assertions.sv
// pin level checks for the dual port memory with parity checker
`timescale 1ns/1ns

module dps_chk (
  input wire       clk_in,
  input wire       arst_n_in,
  input wire       dev_clk_in,
  input wire       proc_port_capture_n_in,
  input wire       proc_port_drive_n_in,
  input wire       sys_port_drive_n_in,
  input wire [7:0] proc_port_bus_out,
  input wire [7:0] sys_port_bus_out,
  input wire       proc_port_oe_out,
  input wire       sys_port_oe_out,
  input wire       parity_fault_n_out,
  input wire       parity_fault_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ****
  // properties
  // ****
  property p_fault_od;
    parity_fault_oe_out == !parity_fault_n_out;
  endproperty
  a_fault_od: assert property (p_fault_od) else $error("fault pin enable wrong");
  property p_pdrv;
    $rose(proc_port_oe_out) |-> !$past(proc_port_drive_n_in, 2);
  endproperty
  a_pdrv: assert property (p_pdrv) else $error("proc driver on without enable");
  property p_sdrv;
    $rose(sys_port_oe_out) |-> !$past(sys_port_drive_n_in, 2);
  endproperty
  a_sdrv: assert property (p_sdrv) else $error("sys driver on without enable");
  // the synchroniser lags the clock pin, so only a settled low phase is judged
  property p_hold;
    !dev_clk_in && !$past(dev_clk_in, 5) |-> $stable(proc_port_bus_out) && $stable(sys_port_bus_out);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved while clock low");
  property p_khigh;
    $changed(proc_port_bus_out) |-> $past(dev_clk_in, 2);
  endproperty
  a_khigh: assert property (p_khigh) else $error("proc data changed outside high phase");
  property p_rst;
    $rose(arst_n_in) |-> !proc_port_oe_out && !sys_port_oe_out && parity_fault_n_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_cap;
    $fell(dev_clk_in) && !proc_port_capture_n_in && !$past(proc_port_capture_n_in, 8)
      |-> ##1 !proc_port_oe_out [*4];
  endproperty
  a_cap: assert property (p_cap) else $error("capturing port drives");
  property p_fault;
    $fell(parity_fault_n_out) |-> $past(proc_port_oe_out, 3) || $past(sys_port_oe_out, 3);
  endproperty
  a_fault: assert property (p_fault) else $error("fault without a read");
  c_bad: cover property ($fell(parity_fault_n_out));
  c_dual: cover property (proc_port_oe_out && sys_port_oe_out);
  c_stream: cover property (sys_port_oe_out && !proc_port_capture_n_in);
endmodule

bind dps_top dps_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .dev_clk_in(dev_clk_in),
  .proc_port_capture_n_in(proc_port_capture_n_in), .proc_port_drive_n_in(proc_port_drive_n_in),
  .sys_port_drive_n_in(sys_port_drive_n_in), .proc_port_bus_out(proc_port_bus_out),
  .sys_port_bus_out(sys_port_bus_out), .proc_port_oe_out(proc_port_oe_out),
  .sys_port_oe_out(sys_port_oe_out), .parity_fault_n_out(parity_fault_n_out),
  .parity_fault_oe_out(parity_fault_oe_out));

// ===== testbench/dps_host.sv
// far side model: both port masters, also making the device clock pin
`timescale 1ns/1ns

module dps_host (
  input  wire        clk_in,
  input  wire        run_in,
  output wire        dev_clk_out,
  output reg  [3:0]  kcnt_out = 4'h0,
  output reg  [14:0] word_index_out = 15'h0000,
  output reg         chip_sel_low_out = 1'b1,
  output reg         chip_sel_high_out = 1'b0,
  output reg  [4:0]  ctl_out = 5'h1f,
  output reg  [8:0]  proc_word_out = 9'h000,
  output reg  [8:0]  sys_word_out = 9'h000
);
  // phases of 8 cycles leave room for the device pin synchroniser
  assign dev_clk_out = kcnt_out[3];

  always @(posedge clk_in) begin
    if (run_in) begin
      kcnt_out <= kcnt_out + 4'h1;
    end
  end

  task wait_cnt;
    input [3:0] n;
    begin
      @(posedge clk_in);
      while (kcnt_out !== n) begin
        @(posedge clk_in);
      end
    end
  endtask

  // index moves mid high phase, controls and data mid low phase
  task access;
    input [14:0] idx;
    input [1:0]  sel;
    input [4:0]  ctl;
    input [8:0]  pw;
    input [8:0]  sw;
    begin
      wait_cnt(4'ha);
      word_index_out <= idx;
      chip_sel_low_out <= sel[1];
      chip_sel_high_out <= sel[0];
      wait_cnt(4'h2);
      // a capturing port never gets its driver enabled
      ctl_out <= ctl | {3'b000, ~ctl[3], ~ctl[2]};
      // a port not sending shows the inverse rather than stale data
      proc_word_out <= ctl[3] ? ~pw : pw;
      sys_word_out <= ctl[2] ? ~sw : sw;
    end
  endtask
endmodule

// ===== testbench/dps_top_test.sv
// self-checking bench for the dual port memory with parity checker
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    checks_done = checks_done + 1; \
    if ((got) !== (exp)) begin \
      err_total = err_total + 1; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module dps_top_test;
  localparam [1:0] SEL = 2'b01;
  reg         clk_in = 1'b0;
  reg         arst_n_in = 1'b0;
  reg         run_q = 1'b0;
  integer     err_total = 0;
  integer     checks_done = 0;
  wire        k_w;
  wire [3:0]  kcnt_w;
  wire [14:0] idx_w;
  wire        csl_w;
  wire        csh_w;
  wire [4:0]  ctl_w;
  wire [8:0]  pdrv_w;
  wire [8:0]  sdrv_w;
  wire [8:0]  pword_w;
  wire [8:0]  sword_w;
  wire        poe_w;
  wire        soe_w;
  wire        fault_n_w;
  wire        fault_oe_w;
  wire [8:0]  pwire_w = poe_w ? pword_w : pdrv_w;
  wire [8:0]  swire_w = soe_w ? sword_w : sdrv_w;

  always #25 clk_in = ~clk_in;

  dps_host host (.clk_in(clk_in), .run_in(run_q), .dev_clk_out(k_w), .kcnt_out(kcnt_w),
    .word_index_out(idx_w), .chip_sel_low_out(csl_w), .chip_sel_high_out(csh_w),
    .ctl_out(ctl_w), .proc_word_out(pdrv_w), .sys_word_out(sdrv_w));

  dps_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1), .dev_clk_in(k_w),
    .word_index_in(idx_w), .chip_sel_low_in(csl_w), .chip_sel_high_in(csh_w),
    .store_sel_n_in(ctl_w[4]), .proc_port_capture_n_in(ctl_w[3]),
    .sys_port_capture_n_in(ctl_w[2]), .proc_port_drive_n_in(ctl_w[1]),
    .sys_port_drive_n_in(ctl_w[0]), .proc_port_bus_in(pwire_w[7:0]),
    .proc_port_check_bit_in(pwire_w[8]), .sys_port_bus_in(swire_w[7:0]),
    .sys_port_check_bit_in(swire_w[8]), .proc_port_bus_out(pword_w[7:0]),
    .proc_port_check_bit_out(pword_w[8]), .proc_port_oe_out(poe_w),
    .sys_port_bus_out(sword_w[7:0]), .sys_port_check_bit_out(sword_w[8]),
    .sys_port_oe_out(soe_w), .parity_fault_n_out(fault_n_w), .parity_fault_oe_out(fault_oe_w));

  function [8:0] odd_w;
    input [7:0] d;
    odd_w = {~^d, d};
  endfunction

  // one access; the pins then repeat it, so the fault seen one period on is its own
  task run_op;
    input [14:0] idx;
    input [1:0]  sel;
    input [4:0]  ctl;
    input [8:0]  pw;
    input [8:0]  sw;
    input [1:0]  eoe;
    input [8:0]  ew;
    input        ef;
    begin
      host.access(idx, sel, ctl, pw, sw);
      host.wait_cnt(4'h8);
      host.wait_cnt(4'h4);
      `CHK({poe_w, soe_w}, eoe)
      if (eoe[1]) `CHK(pword_w, ew)
      if (eoe[0]) `CHK(sword_w, ew)
      host.wait_cnt(4'he);
      `CHK({fault_n_w, fault_oe_w}, {ef, ~ef})
    end
  endtask

  task t_write_read;
    reg [8:0] wa;
    reg [8:0] wb;
    begin
      wa = odd_w(8'h5a);
      wb = odd_w(8'hc3) ^ 9'h100;
      run_op(15'h0000, SEL, 5'b00111, wa, 9'h0, 2'b00, 9'h0, 1'b1);
      run_op(15'h7fff, SEL, 5'b01011, 9'h0, wb, 2'b00, 9'h0, 1'b1);
      run_op(15'h0000, SEL, 5'b11101, 9'h0, 9'h0, 2'b10, wa, 1'b1);
      run_op(15'h7fff, SEL, 5'b11110, 9'h0, 9'h0, 2'b01, wb, 1'b0);
      run_op(15'h7fff, SEL, 5'b11100, 9'h0, 9'h0, 2'b11, wb, 1'b0);
      run_op(15'h7fff, SEL, 5'b11111, 9'h0, 9'h0, 2'b00, 9'h0, 1'b1);
    end
  endtask

  task t_stream;
    reg [8:0] wc;
    reg [8:0] wd;
    reg [8:0] we;
    begin
      wc = odd_w(8'h81) ^ 9'h100;
      wd = odd_w(8'h3c);
      we = odd_w(8'h77) ^ 9'h100;
      run_op(15'h1234, SEL, 5'b00110, wc, 9'h0, 2'b01, wc, 1'b1);
      run_op(15'h1234, SEL, 5'b11101, 9'h0, 9'h0, 2'b10, wc, 1'b0);
      run_op(15'h0055, SEL, 5'b01001, 9'h0, wd, 2'b10, wd, 1'b1);
      run_op(15'h0055, SEL, 5'b10110, we, 9'h0, 2'b01, we, 1'b1);
      run_op(15'h0055, SEL, 5'b11001, 9'h0, wc, 2'b10, wc, 1'b1);
      run_op(15'h0055, SEL, 5'b11110, 9'h0, 9'h0, 2'b01, wd, 1'b1);
    end
  endtask

  task t_nop_standby;
    reg [8:0] wd;
    begin
      wd = odd_w(8'h3c);
      run_op(15'h0055, SEL, 5'b00011, 9'h0aa, 9'h011, 2'b00, 9'h0, 1'b1);
      run_op(15'h0055, SEL, 5'b01111, 9'h0aa, 9'h011, 2'b00, 9'h0, 1'b1);
      run_op(15'h7fff, 2'b11, 5'b11100, 9'h0, 9'h0, 2'b00, 9'h0, 1'b1);
      run_op(15'h7fff, 2'b00, 5'b11100, 9'h0, 9'h0, 2'b00, 9'h0, 1'b1);
      run_op(15'h0055, SEL, 5'b11101, 9'h0, 9'h0, 2'b10, wd, 1'b1);
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    `CHK({poe_w, soe_w, fault_n_w}, 3'b001)
    run_q <= 1'b1;
    t_write_read;
    t_stream;
    t_nop_standby;
    wrap_up;
  end

  // the sequence needs about 900 cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    err_total = err_total + 1;
    wrap_up;
  end
endmodule
